// >>> evtime_defines.svh
`ifndef EVTIME_DEFINES_SVH
`define EVTIME_DEFINES_SVH

`define EVT_NUM_UNITS      5
`define EVT_CNT_W          16
`define EVT_IDX_W          3
`define EVT_HL_DEPTH       64
`define EVT_HL_PTR_W       6
`define EVT_POS_W          15
`define EVT_CLK_HZ         50000000
`define EVT_MS_PER_SEC     1000
`define EVT_CLK_PER_MS     (`EVT_CLK_HZ / `EVT_MS_PER_SEC)
`define EVT_BEEP_LEN_MS    50
`define EVT_BEEP_TONE_DIV  12500
`define EVT_BAUD_DIV_DEF   5208
`define EVT_CNT_MAX        16'hFFFF

`endif

// >>> evtime_pkg.sv
package evtime_pkg;
  `include "evtime_defines.svh"
  typedef logic [`EVT_CNT_W-1:0] val16_t;
  typedef logic [`EVT_IDX_W-1:0] unit_idx_t;
  typedef logic [`EVT_POS_W-1:0] buf_pos_t;
  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b00,
    SEQ_RUN     = 2'b01,
    SEQ_WAIT    = 2'b10,
    SEQ_HALTED  = 2'b11
  } seq_state_t;
endpackage

// >>> stamp_gen.sv
`timescale 1ns/1ns
module stamp_gen
  import evtime_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [15:0] bit_div_i,
  input  wire logic        enable_i,
  output logic             stamp_o
);
  logic [15:0] div_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_r   <= 16'h0000;
      stamp_o <= 1'b0;
    end else if (!enable_i) begin
      div_r   <= 16'h0000;
      stamp_o <= 1'b0;
    end else if (div_r >= bit_div_i) begin
      div_r   <= 16'h0000;
      stamp_o <= 1'b1;
    end else begin
      div_r   <= div_r + 16'h0001;
      stamp_o <= 1'b0;
    end
  end
endmodule

// >>> beep_gen.sv
`timescale 1ns/1ns
module beep_gen
  import evtime_pkg::*;
#(
  parameter int BEEP_CYCLES = `EVT_BEEP_LEN_MS * `EVT_CLK_PER_MS,
  parameter int TONE_DIV    = `EVT_BEEP_TONE_DIV
)(
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  input  wire logic beep_i,
  output logic      tone_o,
  output logic      busy_o
);
  logic [31:0] len_r;
  logic [31:0] tone_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      len_r <= 32'h0000_0000;
    end else if (beep_i) begin
      len_r <= 32'(BEEP_CYCLES);
    end else if (len_r != 32'h0000_0000) begin
      len_r <= len_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tone_r <= 32'h0000_0000;
      tone_o <= 1'b0;
    end else if (len_r == 32'h0000_0000) begin
      tone_r <= 32'h0000_0000;
      tone_o <= 1'b0;
    end else if (tone_r >= 32'(TONE_DIV - 1)) begin
      tone_r <= 32'h0000_0000;
      tone_o <= ~tone_o;
    end else begin
      tone_r <= tone_r + 32'h0000_0001;
    end
  end

  assign busy_o = (len_r != 32'h0000_0000);
endmodule

// >>> trigger_event_timers_counters.sv
`timescale 1ns/1ns
module trigger_event_timers_counters
  import evtime_pkg::*;
#(
  parameter int NUM_UNITS   = `EVT_NUM_UNITS,
  parameter int HL_DEPTH    = `EVT_HL_DEPTH,
  parameter int BEEP_CYCLES = `EVT_BEEP_LEN_MS * `EVT_CLK_PER_MS
)(
  input  wire logic                 core_clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 run_start_i,
  input  wire logic                 stop_tests_i,
  input  wire logic                 trig_event_i,
  input  wire logic [`EVT_POS_W-1:0] trig_pos_i,
  input  wire logic                 trig_wait_i,
  input  wire logic                 beep_cmd_i,
  input  wire logic                 hl_cmd_i,
  input  wire logic                 tmr_start_i,
  input  wire logic                 tmr_stop_i,
  input  wire logic                 tmr_reset_i,
  input  wire logic [2:0]           tmr_idx_i,
  input  wire logic [15:0]          tmr_thresh_i,
  input  wire logic                 cnt_inc_i,
  input  wire logic                 cnt_reset_i,
  input  wire logic [2:0]           cnt_idx_i,
  input  wire logic [15:0]          cnt_step_i,
  input  wire logic [15:0]          cnt_cmp_i,
  input  wire logic                 char_valid_i,
  input  wire logic                 char_filtered_i,
  input  wire logic                 bop_hold_stamp_i,
  input  wire logic                 timing_info_en_i,
  input  wire logic [15:0]          bit_div_i,
  input  wire logic                 disc_store_i,
  input  wire logic                 cur_start_i,
  input  wire logic                 cur_end_i,
  input  wire logic [`EVT_POS_W-1:0] cur_pos_i,
  input  wire logic [`EVT_POS_W-1:0] wr_pos_i,
  input  wire logic [`EVT_POS_W-1:0] rd_pos_i,
  input  wire logic                 rd_is_trans_i,
  output logic                      store_en_o,
  output logic                      stamp_store_o,
  output logic                      running_o,
  output logic                      wait_busy_o,
  output logic                      beep_o,
  output logic                      tmr_trig_o,
  output logic                      cnt_gt_o,
  output logic                      cnt_ovf_o,
  output logic [2:0]                cnt_ovf_idx_o,
  output logic [15:0]               tmr_val_o,
  output logic [15:0]               cnt_val_o,
  output logic [15:0]               cur_time_o,
  output logic                      cur_done_o,
  output logic                      rd_hl_o,
  output logic                      rd_halfbright_o,
  output logic                      rd_second_line_o,
  output logic [6:0]                hl_count_o
);
  localparam logic [15:0] MAX16 = `EVT_CNT_MAX;

  seq_state_t seq_r;
  logic       stamp_raw;
  logic       stamp_ok;
  logic       tone;
  logic       beep_busy;
  logic [`EVT_POS_W-1:0] last_trig_pos_r;
  logic [15:0] tmr_r [NUM_UNITS];
  logic        tmr_run_r [NUM_UNITS];
  logic [15:0] cnt_r [NUM_UNITS];
  logic [`EVT_POS_W-1:0] hl_pos_r [HL_DEPTH];
  logic [HL_DEPTH-1:0]   hl_vld_r;
  logic [5:0]  hl_wp_r;
  logic [15:0] stamp_cnt_r;
  logic [15:0] cur_base_r;
  logic        cur_arm_r;
  logic        stamp_hold_r;
  logic        hl_hit;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == MAX16) ? v : v + 16'h0001;
  endfunction

  function automatic logic sel(input logic [2:0] idx, input int u);
    sel = (int'(idx) == u + 1);
  endfunction

  stamp_gen u_stamp (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .bit_div_i  (bit_div_i),
    .enable_i   (running_o),
    .stamp_o    (stamp_raw)
  );

  beep_gen #(
    .BEEP_CYCLES (BEEP_CYCLES)
  ) u_beep (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .beep_i     (beep_cmd_i && running_o),
    .tone_o     (tone),
    .busy_o     (beep_busy)
  );

  // shared stamp within bit-protocol frame edges
  assign stamp_ok = stamp_raw && timing_info_en_i && !bop_hold_stamp_i;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seq_r <= SEQ_IDLE;
    end else begin
      case (seq_r)
        SEQ_IDLE:   if (run_start_i) seq_r <= SEQ_RUN;
        SEQ_RUN: begin
          if (stop_tests_i) seq_r <= SEQ_HALTED;
          else if (trig_wait_i && !trig_event_i) seq_r <= SEQ_WAIT;
        end
        SEQ_WAIT: begin
          if (stop_tests_i) seq_r <= SEQ_HALTED;
          else if (trig_event_i) seq_r <= SEQ_RUN;
        end
        SEQ_HALTED: if (run_start_i) seq_r <= SEQ_RUN;
        default:    seq_r <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      running_o   <= 1'b0;
      wait_busy_o <= 1'b0;
      store_en_o  <= 1'b0;
    end else begin
      running_o   <= (seq_r == SEQ_RUN) || (seq_r == SEQ_WAIT);
      wait_busy_o <= (seq_r == SEQ_WAIT);
      store_en_o  <= char_valid_i && !char_filtered_i;
    end
  end

  // position is the final matched character
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_trig_pos_r <= '0;
    end else if (trig_event_i) begin
      last_trig_pos_r <= trig_pos_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stamp_store_o <= 1'b0;
      stamp_hold_r  <= 1'b0;
    end else begin
      stamp_store_o <= stamp_ok;
      stamp_hold_r  <= bop_hold_stamp_i;
    end
  end

  // count stamps between start and stop
  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_tmr
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        tmr_r[u]     <= 16'h0000;
        tmr_run_r[u] <= 1'b0;
      end else if (run_start_i) begin
        tmr_r[u]     <= 16'h0000;
        tmr_run_r[u] <= 1'b0;
      end else begin
        if (stop_tests_i || (tmr_stop_i && sel(tmr_idx_i, u))) begin
          tmr_run_r[u] <= 1'b0;
        end else if (tmr_start_i && sel(tmr_idx_i, u)) begin
          tmr_run_r[u] <= 1'b1;
        end
        if (tmr_reset_i && sel(tmr_idx_i, u)) begin
          tmr_r[u] <= 16'h0000;
        end else if (tmr_run_r[u] && stamp_ok && running_o) begin
          tmr_r[u] <= sat_inc(tmr_r[u]);
        end
      end
    end
  end

  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_cnt
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        cnt_r[u] <= 16'h0000;
      end else if (run_start_i) begin
        cnt_r[u] <= 16'h0000;
      end else if (cnt_reset_i && sel(cnt_idx_i, u)) begin
        cnt_r[u] <= 16'h0000;
      end else if (cnt_inc_i && sel(cnt_idx_i, u)) begin
        cnt_r[u] <= cnt_r[u] + cnt_step_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ovf_o     <= 1'b0;
      cnt_ovf_idx_o <= 3'h0;
    end else begin
      cnt_ovf_o     <= 1'b0;
      cnt_ovf_idx_o <= cnt_idx_i;
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (cnt_inc_i && !cnt_reset_i && !run_start_i && sel(cnt_idx_i, u) &&
            ({1'b0, cnt_r[u]} + {1'b0, cnt_step_i} > 17'h0FFFF)) begin
          cnt_ovf_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_gt_o   <= 1'b0;
      tmr_trig_o <= 1'b0;
      cnt_val_o  <= 16'h0000;
      tmr_val_o  <= 16'h0000;
    end else begin
      cnt_gt_o   <= 1'b0;
      tmr_trig_o <= 1'b0;
      cnt_val_o  <= 16'h0000;
      tmr_val_o  <= 16'h0000;
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (sel(cnt_idx_i, u)) begin
          cnt_val_o <= cnt_r[u];
          cnt_gt_o  <= (cnt_r[u] > cnt_cmp_i);
        end
        if (sel(tmr_idx_i, u)) begin
          tmr_val_o  <= tmr_r[u];
          tmr_trig_o <= (tmr_r[u] > tmr_thresh_i);
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hl_vld_r <= '0;
      hl_wp_r  <= 6'h00;
    end else if (disc_store_i || run_start_i) begin
      hl_vld_r <= '0;
      hl_wp_r  <= 6'h00;
    end else if (hl_cmd_i && running_o) begin
      hl_vld_r[hl_wp_r] <= 1'b1;
      hl_wp_r           <= hl_wp_r + 6'h01;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (hl_cmd_i && running_o) begin
      hl_pos_r[hl_wp_r] <= last_trig_pos_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hl_count_o <= 7'h00;
    end else begin
      hl_count_o <= 7'h00;
      for (int i = 0; i < HL_DEPTH; i++) begin
        if (hl_vld_r[i]) hl_count_o <= 7'(i + 1) > hl_count_o ? 7'(i + 1) : hl_count_o;
      end
    end
  end

  always_comb begin
    hl_hit = 1'b0;
    for (int i = 0; i < HL_DEPTH; i++) begin
      if (hl_vld_r[i] && hl_pos_r[i] == rd_pos_i) hl_hit = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_hl_o          <= 1'b0;
      rd_halfbright_o  <= 1'b0;
      rd_second_line_o <= 1'b0;
    end else begin
      rd_hl_o          <= hl_hit;
      rd_halfbright_o  <= hl_hit;
      rd_second_line_o <= rd_is_trans_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stamp_cnt_r <= 16'h0000;
    end else if (run_start_i) begin
      stamp_cnt_r <= 16'h0000;
    end else if (stamp_ok) begin
      stamp_cnt_r <= sat_inc(stamp_cnt_r);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_base_r <= 16'h0000;
      cur_arm_r  <= 1'b0;
      cur_time_o <= 16'h0000;
      cur_done_o <= 1'b0;
    end else begin
      cur_done_o <= 1'b0;
      if (cur_start_i) begin
        cur_base_r <= 16'(cur_pos_i);
        cur_arm_r  <= 1'b1;
      end else if (cur_end_i && cur_arm_r) begin
        cur_time_o <= 16'(cur_pos_i) - cur_base_r;
        cur_done_o <= 1'b1;
        cur_arm_r  <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      beep_o <= 1'b0;
    end else begin
      beep_o <= tone && beep_busy;
    end
  end
endmodule

// >>> evt_properties.sv
`timescale 1ns/1ns
module evt_props (
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  input wire logic        run_start_i,
  input wire logic        stop_tests_i,
  input wire logic        tmr_start_i,
  input wire logic        tmr_stop_i,
  input wire logic        tmr_reset_i,
  input wire logic [2:0]  tmr_idx_i,
  input wire logic        cnt_inc_i,
  input wire logic        cnt_reset_i,
  input wire logic [2:0]  cnt_idx_i,
  input wire logic [15:0] cnt_step_i,
  input wire logic        disc_store_i,
  input wire logic        running_o,
  input wire logic [15:0] tmr_val_o,
  input wire logic [15:0] cnt_val_o,
  input wire logic [6:0]  hl_count_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_stop_held;
    tmr_stop_i && !tmr_start_i && !tmr_reset_i && !run_start_i
    ##1 ($stable(tmr_idx_i) && !tmr_start_i && !tmr_reset_i && !run_start_i) [*3];
  endsequence
  sequence s_inc_held;
    cnt_inc_i && !cnt_reset_i && !run_start_i && cnt_idx_i inside {[3'h1:3'h5]}
    ##1 $stable(cnt_idx_i);
  endsequence
  property p_run;
    run_start_i && !stop_tests_i ##1 !stop_tests_i |-> ##[0:1] running_o;
  endproperty
  a_run: assert property (p_run) else $error("run did not start");
  property p_halt;
    stop_tests_i && !run_start_i ##1 !run_start_i |-> ##[0:1] !running_o;
  endproperty
  a_halt: assert property (p_halt) else $error("run did not halt");
  property p_tmr_freeze;
    s_stop_held |-> $stable(tmr_val_o);
  endproperty
  a_tmr_freeze: assert property (p_tmr_freeze) else $error("stopped timer moved");
  property p_tmr_rst;
    tmr_reset_i ##1 $stable(tmr_idx_i) |-> ##1 tmr_val_o == 16'h0000;
  endproperty
  a_tmr_rst: assert property (p_tmr_rst) else $error("timer not cleared");
  property p_tmr_run_clr;
    run_start_i |-> ##2 tmr_val_o == 16'h0000;
  endproperty
  a_tmr_run_clr: assert property (p_tmr_run_clr) else $error("timer kept at run");
  property p_cnt_add;
    s_inc_held |-> ##1 cnt_val_o == $past(cnt_val_o) + $past(cnt_step_i, 2);
  endproperty
  a_cnt_add: assert property (p_cnt_add) else $error("counter sum wrong");
  property p_cnt_rst;
    cnt_reset_i ##1 $stable(cnt_idx_i) |-> ##1 cnt_val_o == 16'h0000;
  endproperty
  a_cnt_rst: assert property (p_cnt_rst) else $error("counter not cleared");
  property p_cnt_run_clr;
    run_start_i && !cnt_inc_i |-> ##2 cnt_val_o == 16'h0000;
  endproperty
  a_cnt_run_clr: assert property (p_cnt_run_clr) else $error("counter kept at run");
  property p_hl_cap;
    hl_count_o <= 7'h40;
  endproperty
  a_hl_cap: assert property (p_hl_cap) else $error("too many marks");
  property p_hl_drop;
    disc_store_i |-> ##[1:2] hl_count_o == 7'h00;
  endproperty
  a_hl_drop: assert property (p_hl_drop) else $error("marks kept on store");
endmodule
bind trigger_event_timers_counters evt_props i_evt_props (.*);

// >>> seq_model.sv
`timescale 1ns/1ns
module seq_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       go_i,
  input  wire logic [3:0] op_i,
  output logic      [9:0] pulse_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_o <= 10'h000;
    end else begin
      pulse_o <= go_i ? (10'h001 << op_i) : 10'h000;
    end
  end
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb;
  import evtime_pkg::*;
  localparam logic [3:0] OP_RUN = 4'h0, OP_HALT = 4'h1, OP_TRIG = 4'h2, OP_HL = 4'h4;
  localparam logic [3:0] OP_BEEP = 4'h3, OP_TGO = 4'h5, OP_TSTOP = 4'h6, OP_TRST = 4'h7;
  localparam logic [3:0] OP_INC = 4'h8, OP_CRST = 4'h9;
  logic        core_clk_i = 1'b0;
  logic        arst_n_i   = 1'b0;
  logic        go         = 1'b0;
  logic [3:0]  op         = 4'h0;
  logic [2:0]  idx        = 3'h0;
  logic [15:0] step       = 16'h0000;
  logic [15:0] cmp        = 16'h0000;
  logic [15:0] thresh     = 16'hFFFF;
  logic [15:0] bit_div    = 16'h0004;
  logic [14:0] trig_pos   = 15'h0000;
  logic [14:0] cur_pos    = 15'h0000;
  logic [14:0] rd_pos     = 15'h0000;
  logic        timing_en  = 1'b1;
  logic        rd_trans   = 1'b0;
  logic        disc       = 1'b0;
  logic        cur_s      = 1'b0;
  logic        cur_e      = 1'b0;
  logic        twait      = 1'b0;
  logic        filt       = 1'b0;
  logic        ovf_seen   = 1'b0;
  logic        stamp_seen = 1'b0;
  logic [9:0]  p;
  logic        running, tmr_trig, cnt_gt, cur_done, rd_hl, rd_half, rd_second;
  logic [15:0] tmr_val, cnt_val, cur_time;
  logic [6:0]  hl_count;
  logic        wait_busy, store_en, stamp_st, beep, ovf;
  logic [2:0]  ovf_idx;
  int          mismatches = 0;
  int          num_checks = 0;
  always #10 core_clk_i = ~core_clk_i;
  // catch one-cycle pulses between checks
  always @(posedge core_clk_i) begin
    if (ovf) ovf_seen <= 1'b1;
    if (stamp_st) stamp_seen <= 1'b1;
  end
  seq_model i_seq_model (.clk_i(core_clk_i), .rst_n_i(arst_n_i), .go_i(go), .op_i(op),
    .pulse_o(p));
  trigger_event_timers_counters #(.BEEP_CYCLES(30000)) i_trigger_event_timers_counters (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .run_start_i(p[0]), .stop_tests_i(p[1]),
    .trig_event_i(p[2]), .trig_pos_i(trig_pos), .trig_wait_i(twait), .beep_cmd_i(p[3]),
    .hl_cmd_i(p[4]), .tmr_start_i(p[5]), .tmr_stop_i(p[6]), .tmr_reset_i(p[7]),
    .tmr_idx_i(idx), .tmr_thresh_i(thresh), .cnt_inc_i(p[8]), .cnt_reset_i(p[9]),
    .cnt_idx_i(idx), .cnt_step_i(step), .cnt_cmp_i(cmp), .char_valid_i(1'b1),
    .char_filtered_i(filt), .bop_hold_stamp_i(1'b0), .timing_info_en_i(timing_en),
    .bit_div_i(bit_div), .disc_store_i(disc), .cur_start_i(cur_s), .cur_end_i(cur_e),
    .cur_pos_i(cur_pos), .wr_pos_i(15'h0000), .rd_pos_i(rd_pos), .rd_is_trans_i(rd_trans),
    .store_en_o(store_en), .stamp_store_o(stamp_st), .running_o(running),
    .wait_busy_o(wait_busy), .beep_o(beep),
    .tmr_trig_o(tmr_trig), .cnt_gt_o(cnt_gt), .cnt_ovf_o(ovf), .cnt_ovf_idx_o(ovf_idx),
    .tmr_val_o(tmr_val), .cnt_val_o(cnt_val), .cur_time_o(cur_time), .cur_done_o(cur_done),
    .rd_hl_o(rd_hl), .rd_halfbright_o(rd_half), .rd_second_line_o(rd_second),
    .hl_count_o(hl_count));
  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic cmd(input logic [3:0] o, input logic [2:0] i, input logic [15:0] s);
    op = o;
    idx = i;
    step = s;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(4);
  endtask
  task automatic t_counters();
    cmd(OP_RUN, 3'h1, 16'h0000);
    chk(cnt_val, 16'h0000);
    ovf_seen = 1'b0;
    cmd(OP_INC, 3'h1, 16'hFFFF);
    chk(cnt_val, 16'hFFFF);
    chk(16'(ovf_seen), 16'h0000);
    cmd(OP_INC, 3'h1, 16'h0001);
    chk(cnt_val, 16'h0000);
    chk(16'(ovf_seen), 16'h0001);
    chk(16'(ovf_idx), 16'h0001);
    cmd(OP_INC, 3'h1, 16'h0002);
    cmd(OP_INC, 3'h1, 16'hFFFE);
    chk(cnt_val, 16'h0000);
    cmd(OP_INC, 3'h2, 16'h0005);
    cmp = 16'h0004;
    tick(3);
    chk(16'(cnt_gt), 16'h0001);
    cmp = 16'h0005;
    tick(3);
    chk(16'(cnt_gt), 16'h0000);
    chk(cnt_val, 16'h0005);
    cmd(OP_INC, 3'h6, 16'h0005);
    chk(cnt_val, 16'h0000);
    cmd(OP_CRST, 3'h2, 16'h0000);
    chk(cnt_val, 16'h0000);
    cmd(OP_INC, 3'h1, 16'h0007);
    cmd(OP_RUN, 3'h1, 16'h0000);
    chk(cnt_val, 16'h0000);
  endtask
  task automatic t_events();
    int n;
    twait = 1'b1;
    tick(3);
    chk(16'(wait_busy), 16'h0001);
    twait = 1'b0;
    tick(3);
    chk(16'(wait_busy), 16'h0001);
    chk(16'(running), 16'h0001);
    cmd(OP_TRIG, 3'h1, 16'h0000);
    chk(16'(wait_busy), 16'h0000);
    filt = 1'b1;
    tick(3);
    chk(16'(store_en), 16'h0000);
    filt = 1'b0;
    tick(3);
    chk(16'(store_en), 16'h0001);
    cmd(OP_BEEP, 3'h1, 16'h0000);
    n = 0;
    while (beep !== 1'b1 && n < 13000) begin
      tick(1);
      n++;
    end
    if (n == 13000) begin
      mismatches++;
      final_report();
    end else begin
      chk(16'(beep), 16'h0001);
    end
  endtask
  task automatic t_timers();
    logic [15:0] v;
    timing_en = 1'b0;
    cmd(OP_RUN, 3'h1, 16'h0000);
    stamp_seen = 1'b0;
    cmd(OP_TRIG, 3'h1, 16'h0000);
    cmd(OP_TGO, 3'h1, 16'h0000);
    tick(200);
    chk(tmr_val, 16'h0000);
    chk(16'(stamp_seen), 16'h0000);
    timing_en = 1'b1;
    tick(200);
    chk(16'(stamp_seen), 16'h0001);
    cmd(OP_TSTOP, 3'h1, 16'h0000);
    v = tmr_val;
    chk(16'(v != 16'h0000), 16'h0001);
    tick(100);
    chk(tmr_val, v);
    thresh = 16'h0000;
    tick(3);
    chk(16'(tmr_trig), 16'h0001);
    cmd(OP_HALT, 3'h1, 16'h0000);
    chk(16'(running), 16'h0000);
    chk(tmr_val, v);
    cmd(OP_TRST, 3'h1, 16'h0000);
    chk(tmr_val, 16'h0000);
    chk(16'(tmr_trig), 16'h0000);
  endtask
  task automatic t_marks();
    cmd(OP_RUN, 3'h1, 16'h0000);
    for (int k = 0; k < 65; k++) begin
      trig_pos = 15'(2 * k);
      cmd(OP_TRIG, 3'h1, 16'h0000);
      cmd(OP_HL, 3'h1, 16'h0000);
    end
    chk(16'(hl_count), 16'h0040);
    rd_pos = 15'h0080;
    rd_trans = 1'b1;
    tick(3);
    chk(16'(rd_hl), 16'h0001);
    chk(16'(rd_half), 16'h0001);
    chk(16'(rd_second), 16'h0001);
    rd_pos = 15'h007F;
    tick(3);
    chk(16'(rd_hl), 16'h0000);
    rd_pos = 15'h0000;
    tick(3);
    chk(16'(rd_hl), 16'h0000);
    disc = 1'b1;
    tick(1);
    disc = 1'b0;
    tick(3);
    chk(16'(hl_count), 16'h0000);
    cmd(OP_HALT, 3'h1, 16'h0000);
    cmd(OP_HL, 3'h1, 16'h0000);
    chk(16'(hl_count), 16'h0000);
  endtask
  task automatic t_cursor();
    int n;
    cur_pos = 15'h000A;
    cur_s = 1'b1;
    tick(1);
    cur_s = 1'b0;
    cur_pos = 15'h0023;
    cur_e = 1'b1;
    tick(1);
    cur_e = 1'b0;
    n = 0;
    while (cur_done !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    if (n == 20) begin
      mismatches++;
      final_report();
    end else begin
      chk(cur_time, 16'h0019);
    end
  endtask
  initial begin
    tick(10);
    arst_n_i = 1'b1;
    tick(1);
    t_counters();
    t_events();
    t_timers();
    t_marks();
    t_cursor();
    final_report();
  end
endmodule
